/* File: inc/xdc_pkg.sv */
// Package for the external data move stretch and timer rate select block
package xdc_pkg;
   // Register map
   localparam logic [7:0] XDC_CTRL_ADDR = 8'h8e;
   localparam logic [7:0] XDC_CTRL_RESET = 8'h01;
   // Field positions
   localparam int XDC_STRETCH_LSB = 0;
   localparam int XDC_T0_POS = 3;
   localparam int XDC_T1_POS = 4;
   localparam int XDC_T2_POS = 5;
   localparam logic [7:0] XDC_WR_MASK = 8'h3f;
   // Timing figures
   localparam logic [3:0] XDC_BASE_CYCLES = 4'h2;
   localparam logic [4:0] XDC_ZERO_STROBE = 5'h02;
   localparam logic [4:0] XDC_SLOW_DIV = 5'h0c;
   localparam logic [4:0] XDC_FAST_DIV = 5'h04;
   localparam logic [4:0] XDC_CLKS_PER_CYCLE = 5'h04;
   localparam logic [15:0] XDC_EXT_BASE = 16'h0300;
   // Move request from the core
   typedef struct packed {
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic from_int_code;
   } xdc_move_t;
   // Bus sequencer states
   typedef enum logic [3:0] {
      XDC_IDLE = 4'b0001,
      XDC_SETUP = 4'b0010,
      XDC_STROBE = 4'b0100,
      XDC_HOLD = 4'b1000
   } xdc_state_t;
endpackage

/* File: sim/xdc_ctrl_chk.sv */
// Port checker for the stretch sequencer and timer rate select
module xdc_ctrl_chk
   import xdc_pkg::*;
(
   // Watched ports
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_move_req,
   input wire xdc_move_t i_move,
   input wire logic i_move_dptr,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic o_move_busy,
   input wire logic o_move_done,
   input wire logic o_write_strobe_pin_n,
   input wire logic o_read_strobe_pin_n,
   input wire logic o_timer0_tick,
   input wire logic o_timer2_tick
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // Register, bus and tick relations
   chk_rsv_zero: assert property (o_sfr_rdata[7:6] == 2'h0) else $error("rsvd");
   chk_strobe_excl: assert property (o_read_strobe_pin_n || o_write_strobe_pin_n) else $error("both");
   chk_strobe_busy: assert property (!(o_read_strobe_pin_n && o_write_strobe_pin_n) |-> o_move_busy) else $error("sb");
   chk_take_start: assert property (!o_move_busy && !o_move_done && i_move_req && i_move_dptr
      && i_move.addr >= XDC_EXT_BASE |=> o_move_busy) else $error("take");
   chk_done_pulse: assert property (o_move_done |-> !o_move_busy ##1 !o_move_done) else $error("done");
   chk_wr_min: assert property ($fell(o_write_strobe_pin_n) |-> !o_write_strobe_pin_n [*2]) else $error("wr");
   chk_t0_gap: assert property (o_timer0_tick |=> !o_timer0_tick [*3]) else $error("t0");
   chk_t2_max: assert property ($fell(o_timer2_tick) |-> ##[1:11] o_timer2_tick) else $error("t2");
   cover property ($fell(o_read_strobe_pin_n));
   cover property (o_move_done);
   cover property (o_timer2_tick ##4 o_timer2_tick);
endmodule // xdc_ctrl_chk
bind xdc_ctrl xdc_ctrl_chk u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_move_req(i_move_req), .i_move(i_move),
   .i_move_dptr(i_move_dptr), .o_sfr_rdata(o_sfr_rdata), .o_move_busy(o_move_busy), .o_move_done(o_move_done),
   .o_write_strobe_pin_n(o_write_strobe_pin_n), .o_read_strobe_pin_n(o_read_strobe_pin_n),
   .o_timer0_tick(o_timer0_tick), .o_timer2_tick(o_timer2_tick));

/* File: sim/xdc_ctrl_tb.sv */
// Self-checking bench for the stretch sequencer and timer rate select
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", n, e, g); end end
module xdc_ctrl_tb
   import xdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   int mismatches = 0, checks_done = 0;
   logic i_clk = 1'b0, i_arst_n = 1'b0, sw = 1'b0, req = 1'b0, dp = 1'b1, oe_n, wn, rn, busy, done;
   logic [7:0] sa = 8'h8e, sd = 8'h00, rd, mrd, pi, po, p2;
   logic [2:0] tk;
   xdc_move_t mv = '0;
   xdc_ctrl u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sfr_wr(sw), .i_sfr_addr(sa), .i_sfr_wdata(sd),
      .o_sfr_rdata(rd), .i_move_req(req), .i_move(mv), .i_move_dptr(dp), .o_move_busy(busy), .o_move_done(done),
      .o_move_rdata(mrd), .i_p0(pi), .o_p0(po), .o_p0_oe_n(oe_n), .o_p2(p2), .o_write_strobe_pin_n(wn),
      .o_read_strobe_pin_n(rn), .o_timer0_tick(tk[0]), .o_timer1_tick(tk[1]), .o_timer2_tick(tk[2]));
   xdc_mem_model u_mem (.i_p0(po), .i_oe_n(oe_n), .i_p2(p2), .i_wr_n(wn), .i_rd_n(rn), .o_p0(pi));
   // 200 MHz clock
   always #2.5 i_clk = ~i_clk;
   // Register access and moves, sampled on the falling edge
   task automatic final_report;
      $display("Checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wr_ctl(input logic [7:0] v);
      @(posedge i_clk);
      sw <= 1'b1;
      sd <= v;
      sa <= XDC_CTRL_ADDR;
      @(posedge i_clk);
      sw <= 1'b0;
   endtask
   task automatic rd_ctl(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk);
      sa <= a;
      repeat (2) @(negedge i_clk);
      `CHK("ctl", e, rd)
   endtask
   task automatic move(input logic w, input logic [15:0] a, input logic [2:0] s);
      int n = 0;
      int k = 0;
      @(posedge i_clk);
      req <= 1'b1;
      mv <= '{w, a, a[7:0] ^ 8'h5a, 1'b0};
      @(posedge i_clk);
      req <= 1'b0;
      while (done !== 1'b1 && n < 80) begin
         @(negedge i_clk);
         n++;
         if (n == 1) `CHK("addr", {a, 1'b0}, {p2, po, oe_n})
         if (k == 0 && !(rn & wn)) `CHK("strb", w ? 2'b01 : 2'b10, {wn, rn})
         if (w && !wn) `CHK("wdat", a[7:0] ^ 8'h5a, po)
         k += int'(!(rn & wn));
      end
      `CHK("len", 4 * (2 + s) + 1, n)
      `CHK("strobe", (s == 3'h0) ? 2 : 4 * s, k)
      if (!w) `CHK("data", a[7:0] ^ 8'h5a, mrd)
      if (n >= 80) final_report;
   endtask
   task automatic refuse(input logic [15:0] a, input logic d);
      logic b = 1'b0;
      logic [15:0] keep;
      @(negedge i_clk);
      keep = {p2, po};
      @(posedge i_clk);
      req <= 1'b1;
      dp <= d;
      mv.addr <= a;
      repeat (8) @(negedge i_clk) b |= busy | !oe_n | !wn | !rn | ({p2, po} != keep);
      @(posedge i_clk);
      req <= 1'b0;
      dp <= 1'b1;
      `CHK("ignored", 1'b0, b)
   endtask
   task automatic gap(input int i, input int e);
      int n = 0;
      repeat (3) begin
         n = 0;
         do begin
            @(negedge i_clk);
            n++;
         end while (tk[i] !== 1'b1 && n < 40);
      end
      `CHK("gap", e, n)
      if (n >= 40) final_report;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge i_clk);
      i_arst_n <= 1'b1;
      rd_ctl(8'h8e, XDC_CTRL_RESET);
      move(1'b1, 16'h8000, 3'h1);
      wr_ctl(8'hff);
      rd_ctl(8'h8e, 8'h3f);
      rd_ctl(8'h8d, 8'h00);
      for (int s = 0; s < 8; s++) begin
         wr_ctl({5'h00, 3'(s)});
         move(1'b1, 16'h8000 + 16'(s), 3'(s));
         move(1'b0, 16'h8000 + 16'(s), 3'(s));
      end
      fork
         move(1'b1, 16'hffff, 3'h7);
         wr_ctl(8'h00);
      join
      move(1'b0, 16'hffff, 3'h0);
      refuse(16'h02ff, 1'b1);
      refuse(16'h8000, 1'b0);
      for (int i = 0; i < 3; i++) gap(i, 12);
      wr_ctl(8'h38);
      for (int i = 0; i < 3; i++) gap(i, 4);
      // Reset in mid-run restores the default stretch
      @(posedge i_clk);
      i_arst_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_arst_n <= 1'b1;
      rd_ctl(8'h8e, XDC_CTRL_RESET);
      move(1'b0, 16'h8000, 3'h1);
      final_report;
   end
endmodule // xdc_ctrl_tb

/* File: sim/xdc_mem_model.sv */
// Behavioural external data memory on the port 0 and port 2 bus
module xdc_mem_model (
   // Bus from the device
   input wire logic [7:0] i_p0,
   input wire logic i_oe_n,
   input wire logic [7:0] i_p2,
   input wire logic i_wr_n,
   input wire logic i_rd_n,
   // Data back to port 0
   output logic [7:0] o_p0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [65536];
   logic [15:0] a = 16'h0000;
   // Address taken while both strobes idle, a moment late: port 0 and the strobe move together
   always @(i_p0, i_p2, i_oe_n, i_wr_n, i_rd_n) #0.1 if (!i_oe_n && i_wr_n && i_rd_n) a = {i_p2, i_p0};
   always @(i_p0, i_wr_n) if (!i_wr_n) mem[a] = i_p0;
   // Released bus shows the inverse so stale data never passes
   assign o_p0 = !i_rd_n ? mem[a] : ~mem[a];
endmodule // xdc_mem_model

/* File: src/xdc_ctrl.sv */
// External data move stretch sequencer and timer rate select
module xdc_ctrl
   import xdc_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Special function register port
   input wire logic i_sfr_wr,
   input wire logic [7:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   // Move request from the core
   input wire logic i_move_req,
   input wire xdc_move_t i_move,
   input wire logic i_move_dptr,
   output logic o_move_busy,
   output logic o_move_done,
   output logic [7:0] o_move_rdata,
   // Port 0 and port 2 bus
   input wire logic [7:0] i_p0,
   output logic [7:0] o_p0,
   output logic o_p0_oe_n,
   output logic [7:0] o_p2,
   output logic o_write_strobe_pin_n,
   output logic o_read_strobe_pin_n,
   // Timer count ticks
   output logic o_timer0_tick,
   output logic o_timer1_tick,
   output logic o_timer2_tick
);

   // Cycle count of a stretched move
   // Two base cycles plus one per stretch step
   function automatic logic [3:0] move_cycles(input logic [2:0] s);
      move_cycles = XDC_BASE_CYCLES + {1'b0, s};
   endfunction

   // Strobe width in clocks
   // Zero stretch is the only width that is not a multiple of four
   function automatic logic [4:0] strobe_clks(input logic [2:0] s);
      if (s == 3'h0) begin
         strobe_clks = XDC_ZERO_STROBE;
      end else begin
         strobe_clks = 5'(XDC_CLKS_PER_CYCLE * s);
      end
   endfunction

   // Prescaler wrap test, shared by the counter and its tick flop
   function automatic logic tick_due(input logic [4:0] pre, input logic fast);
      logic [4:0] div;
      div = fast ? XDC_FAST_DIV : XDC_SLOW_DIV;
      tick_due = (pre + 5'h01 >= div);
   endfunction

   // Register and sequencer state
   logic [7:0] ctrl_r;
   logic [2:0] stretch_r;
   xdc_state_t state_r;
   logic [4:0] cnt_r;
   logic wr_r;
   logic [7:0] rdata_r;
   logic [4:0] pre_r [3];

   // Prescaler select and move decode
   logic [2:0] tick_sel;
   logic ext_hit;

   // Rate select bits gathered in timer order
   assign tick_sel = {ctrl_r[XDC_T2_POS], ctrl_r[XDC_T1_POS], ctrl_r[XDC_T0_POS]};
   // Only data-pointer moves above the on-chip block reach the pins
   assign ext_hit = i_move_req && i_move_dptr && (i_move.addr >= XDC_EXT_BASE);

   // Control register, upper bits held at zero
   // Masking on write keeps the read path free of gating
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_r <= XDC_CTRL_RESET;
      end else if (i_sfr_wr && i_sfr_addr == XDC_CTRL_ADDR) begin
         ctrl_r <= i_sfr_wdata & XDC_WR_MASK;
      end
   end

   // Registered read data
   // Other addresses read zero, so reads can be OR-ed with other registers
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_sfr_rdata <= 8'h00;
      end else begin
         o_sfr_rdata <= (i_sfr_addr == XDC_CTRL_ADDR) ? ctrl_r : 8'h00;
      end
   end

   // Timer prescalers, one per timer
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int k = 0; k < 3; k++) begin
            pre_r[k] <= 5'h00;
         end
         o_timer0_tick <= 1'b0;
         o_timer1_tick <= 1'b0;
         o_timer2_tick <= 1'b0;
      end else begin
         for (int k = 0; k < 3; k++) begin
            // Rate change restarts nothing; a wrap catches up within one period
            if (tick_due(pre_r[k], tick_sel[k])) begin
               pre_r[k] <= 5'h00;
            end else begin
               pre_r[k] <= pre_r[k] + 5'h01;
            end
         end
         // Ticks mirror the wrap, so each is one clock wide
         o_timer0_tick <= tick_due(pre_r[0], tick_sel[0]);
         o_timer1_tick <= tick_due(pre_r[1], tick_sel[1]);
         o_timer2_tick <= tick_due(pre_r[2], tick_sel[2]);
      end
   end

   // Bus sequencer: setup, strobe, hold; stretch latched at start
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= XDC_IDLE;
         stretch_r <= XDC_CTRL_RESET[2:0];
         cnt_r <= 5'h00;
         wr_r <= 1'b0;
         o_move_busy <= 1'b0;
         o_move_done <= 1'b0;
      end else begin
         o_move_done <= 1'b0;
         case (state_r)
            XDC_IDLE: begin
               // Stretch latched here so a rewrite cannot bend a running move
               if (ext_hit) begin
                  stretch_r <= ctrl_r[2:0];
                  wr_r <= i_move.wr;
                  o_move_busy <= 1'b1;
                  // Setup plus hold use what the strobe leaves of the move
                  cnt_r <= 5'(XDC_CLKS_PER_CYCLE * move_cycles(ctrl_r[2:0]) - strobe_clks(ctrl_r[2:0])) - 5'h02;
                  state_r <= XDC_SETUP;
               end
            end
            XDC_SETUP: begin
               // Address phase until the setup count runs out
               if (cnt_r == 5'h00) begin
                  cnt_r <= strobe_clks(stretch_r) - 5'h01;
                  state_r <= XDC_STROBE;
               end else begin
                  cnt_r <= cnt_r - 5'h01;
               end
            end
            XDC_STROBE: begin
               // Strobe held for the latched width
               if (cnt_r == 5'h00) begin
                  state_r <= XDC_HOLD;
               end else begin
                  cnt_r <= cnt_r - 5'h01;
               end
            end
            XDC_HOLD: begin
               // One quiet clock lets the bus turn round before done
               o_move_busy <= 1'b0;
               o_move_done <= 1'b1;
               state_r <= XDC_IDLE;
            end
            default: begin
               // Any stray code falls back to idle
               state_r <= XDC_IDLE;
            end
         endcase
      end
   end

   // Pin drive; internal hits never touch pins
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_p0 <= 8'hff;
         o_p0_oe_n <= 1'b1;
         o_p2 <= 8'hff;
         o_write_strobe_pin_n <= 1'b1;
         o_read_strobe_pin_n <= 1'b1;
         rdata_r <= 8'h00;
      end else begin
         if (state_r == XDC_IDLE && ext_hit) begin
            // Address phase: both bytes out, port 0 driven
            o_p0 <= i_move.addr[7:0];
            o_p2 <= i_move.addr[15:8];
            o_p0_oe_n <= 1'b0;
         end else if (state_r == XDC_SETUP && cnt_r == 5'h00) begin
            // Strobe opens; a read hands port 0 to the memory
            o_p0 <= i_move.wdata;
            o_p0_oe_n <= !wr_r; // Release port 0 for reads
            o_write_strobe_pin_n <= !wr_r;
            o_read_strobe_pin_n <= wr_r;
         end else if (state_r == XDC_STROBE && cnt_r == 5'h00) begin
            // Sample read data while the strobe is still low
            rdata_r <= i_p0;
            o_write_strobe_pin_n <= 1'b1;
            o_read_strobe_pin_n <= 1'b1;
         end else if (state_r == XDC_HOLD) begin
            // Hold done; port 0 floats again
            o_p0_oe_n <= 1'b1;
         end
      end
   end

   // Read data stands until the strobe of the next move, read or write, closes
   assign o_move_rdata = rdata_r;

endmodule // xdc_ctrl
